// ### verilog/i2c_host_pkg.sv
package i2c_host_pkg;

    // Register addresses on the plain register port
    localparam logic [2:0] ADDR_CTRL1  = 3'h0;
    localparam logic [2:0] ADDR_CTRL2  = 3'h1;
    localparam logic [2:0] ADDR_STATUS = 3'h2;
    localparam logic [2:0] ADDR_RELOAD = 3'h3;
    localparam logic [2:0] ADDR_BUF    = 3'h4;
    localparam logic [2:0] ADDR_FLAGS  = 3'h5;

    // Control one fields
    localparam int CTRL1_WRITE_COLLISION_FLAG   = 7;
    localparam int CTRL1_ENABLE = 5;

    // Control two fields
    localparam int CTRL2_ACKSTAT = 6;
    localparam int CTRL2_ACK_VALUE_BIT   = 5;
    localparam int CTRL2_ACK_SEQ_ENABLE   = 4;
    localparam int CTRL2_STOP    = 2;
    localparam int CTRL2_RSTART  = 1;
    localparam int CTRL2_START   = 0;

    // Status fields
    localparam int STAT_STOP_SEEN  = 4;
    localparam int STAT_START_SEEN = 3;
    localparam int STAT_BUF_FULL   = 0;

    // Flag register fields, write one to clear
    localparam int FLAG_EVENT = 0;
    localparam int FLAG_COLL  = 1;

    localparam logic [7:0] RELOAD_RESET = 8'h4F;

    // Two counter rollovers per bus clock, bus clock = mclk/(4*(n+1))
    localparam int RELOAD_CLOCKS_PER_COUNT = 2;

    typedef enum logic [4:0] {
        ST_IDLE,
        ST_START_CHK, ST_START_HOLD, ST_START_SCL,
        ST_RS_SDA, ST_RS_SCLHI, ST_RS_HOLD, ST_RS_SCL,
        ST_TX_LOW, ST_TX_HIGH, ST_ACKIN_LOW, ST_ACKIN_HIGH,
        ST_ACK_LOW, ST_ACK_WAIT, ST_ACK_HIGH,
        ST_STOP_SDA, ST_STOP_SCL, ST_STOP_WAIT, ST_STOP_DONE
    } seq_state_t;

endpackage : i2c_host_pkg

// ### verilog/rate_counter.sv
module rate_counter (
    // Clocking
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic       clk_en,
    // Control
    input  wire logic       load,
    input  wire logic       run,
    input  wire logic [7:0] reload,
    // Status
    output logic            tick
);

    // One count step every second mclk: four mclk per reload+1 per bus clock
    logic [7:0] cnt_ff;
    logic       half_ff;

    assign tick = run && !load && (cnt_ff == 8'h00) && half_ff;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cnt_ff  <= 8'h00;
            half_ff <= 1'b0;
        end else if (clk_en) begin
            if (load || tick || !run) begin
                cnt_ff  <= reload;
                half_ff <= 1'b0;
            end else begin
                half_ff <= !half_ff;
                if (half_ff)
                    cnt_ff <= cnt_ff - 8'h01;
            end
        end
    end

endmodule : rate_counter

// ### verilog/i2c_host_ctrl.sv
// Contract
// - Acknowledge enable pulls SCL low and puts ack value on SDA.
// - Ack: one period, release SCL, wait high, one period, low, idle.
// - Buffer write during ack or stop ignored, sets write collision.
// - Stop: SDA low, count, release SCL, one period later release SDA.
// - SDA high with SCL high sets stop seen and event flag; event flag again a period later.
// - Sleep wake on target address match or byte; target mode absent.
// - Reset disables block and aborts the transfer in progress.
// - Start and stop seen bits clear on reset and when disabled.
// - Releasing SDA for a one, low SDA with SCL high is collision.
// - Arbitration checked in address, data, start, restart, ack.
// - Transmit collision halts, clears buffer full, releases lines.
// - Condition collision aborts, releases lines, clears request bit.
// - After collision keep watching; bus stop sets event flag.
// - After collision a buffer write restarts from the first bit.
// - Either line low when start begins: abort, flag collision.
// - Start: SDA low reloads counter; SCL low with SDA high collides.
// - SDA low early drives SDA low early; then count, SCL low.
// - Restart: release SDA, count, release SCL, sample SDA when high.
// - Restart hold: SDA falling fine, SCL falling early collides.
// - Both high at timeout: SDA low, count, SCL low, done.
// - Ack bit clocked out to target sets event flag.
// - Bus clock is mclk over four times reload plus one.
module i2c_host_ctrl (
    // Clocking
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic       clk_en,
    // Register port
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Bus pins, enable high pulls the line low
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // Events
    output logic            serial_event_flag,
    output logic            bus_collision_flag
);

    i2c_host_pkg::seq_state_t state_ff;
    logic [7:0] reload_ff;
    logic [7:0] shift_data_buffer;
    logic [7:0] shreg_ff;
    logic [2:0] bit_ff;
    logic       enable_ff;
    logic       write_collision_flag;
    logic       buffer_full_flag;
    logic       ack_value_bit;
    logic       ack_seq_enable;
    logic       stop_request_bit;
    logic       start_request_bit;
    logic       rstart_ff;
    logic       ackstat_ff;
    logic       start_seen_ff;
    logic       stop_seen_ff;
    logic       scl_low_ff;
    logic       sda_low_ff;
    logic       sda_d_ff;
    logic       scl_d_ff;
    logic       cnt_load;
    logic       cnt_run;
    logic       tick;
    logic       coll;
    logic       busy_seq;
    logic       buf_wr;
    logic       bus_stop;
    logic       bus_start;
    logic       ev_set;
    logic       done_ev;

    // Clear pins drive low; lines float high when released
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe  = scl_low_ff;
    assign sda_oe  = sda_low_ff;

    assign busy_seq = (state_ff != i2c_host_pkg::ST_IDLE);
    assign buf_wr   = reg_wr && (reg_addr == i2c_host_pkg::ADDR_BUF);
    assign bus_stop  = scl_in && scl_d_ff && sda_in && !sda_d_ff;
    assign bus_start = scl_in && scl_d_ff && !sda_in && sda_d_ff;

    rate_counter u_rate (
        .mclk   (mclk),
        .resetn (resetn),
        .clk_en (clk_en),
        .load   (cnt_load),
        .run    (cnt_run),
        .reload (reload_ff),
        .tick   (tick)
    );

    // Collision detection per state
    always_comb begin
        coll = 1'b0;
        unique case (state_ff)
            i2c_host_pkg::ST_START_CHK:
                coll = !sda_in || !scl_in;
            i2c_host_pkg::ST_START_HOLD:
                coll = sda_in && !scl_in;
            i2c_host_pkg::ST_RS_SCLHI:
                coll = scl_in && !sda_in;
            i2c_host_pkg::ST_RS_HOLD:
                coll = !scl_in && sda_in;
            i2c_host_pkg::ST_TX_HIGH:
                coll = scl_in && shreg_ff[7] && !sda_in;
            i2c_host_pkg::ST_ACK_HIGH:
                coll = scl_in && ack_value_bit && !sda_in;
            i2c_host_pkg::ST_STOP_DONE:
                coll = tick && !sda_in;
            default:
                coll = 1'b0;
        endcase
    end

    // Counter control: held loaded outside timed phases
    always_comb begin
        cnt_run  = 1'b1;
        cnt_load = 1'b0;
        unique case (state_ff)
            i2c_host_pkg::ST_IDLE, i2c_host_pkg::ST_START_CHK:
                cnt_run = 1'b0;
            i2c_host_pkg::ST_START_HOLD:
                cnt_load = !sda_in;
            i2c_host_pkg::ST_ACK_WAIT, i2c_host_pkg::ST_RS_SCLHI:
                cnt_run = 1'b0;
            i2c_host_pkg::ST_RS_HOLD:
                cnt_load = !sda_in;
            i2c_host_pkg::ST_TX_HIGH, i2c_host_pkg::ST_ACKIN_HIGH,
            i2c_host_pkg::ST_STOP_WAIT:
                cnt_load = !scl_in;
            i2c_host_pkg::ST_STOP_SDA:
                cnt_load = 1'b1;
            default:
                cnt_run = 1'b1;
        endcase
    end

    // Sequencer
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_ff   <= i2c_host_pkg::ST_IDLE;
            scl_low_ff <= 1'b0;
            sda_low_ff <= 1'b0;
            bit_ff     <= 3'h0;
            shreg_ff   <= 8'h00;
            ackstat_ff <= 1'b0;
        end else if (clk_en) begin
            if (!enable_ff || coll) begin
                state_ff   <= i2c_host_pkg::ST_IDLE;
                scl_low_ff <= 1'b0;
                sda_low_ff <= 1'b0;
                bit_ff     <= 3'h0;
            end else begin
                unique case (state_ff)
                    i2c_host_pkg::ST_IDLE: begin
                        bit_ff <= 3'h0;
                        if (start_request_bit) begin
                            state_ff <= i2c_host_pkg::ST_START_CHK;
                        end else if (rstart_ff) begin
                            sda_low_ff <= 1'b0;
                            state_ff   <= i2c_host_pkg::ST_RS_SDA;
                        end else if (stop_request_bit) begin
                            sda_low_ff <= 1'b1;
                            state_ff   <= i2c_host_pkg::ST_STOP_SDA;
                        end else if (ack_seq_enable) begin
                            scl_low_ff <= 1'b1;
                            sda_low_ff <= !ack_value_bit;
                            state_ff   <= i2c_host_pkg::ST_ACK_LOW;
                        end else if (buf_wr && !buffer_full_flag) begin
                            shreg_ff   <= reg_wdata;
                            scl_low_ff <= 1'b1;
                            state_ff   <= i2c_host_pkg::ST_TX_LOW;
                        end
                    end
                    i2c_host_pkg::ST_START_CHK:
                        state_ff <= i2c_host_pkg::ST_START_HOLD;
                    i2c_host_pkg::ST_START_HOLD:
                        if (!sda_in || tick) begin
                            sda_low_ff <= 1'b1;
                            state_ff   <= i2c_host_pkg::ST_START_SCL;
                        end
                    i2c_host_pkg::ST_START_SCL, i2c_host_pkg::ST_RS_SCL:
                        if (tick) begin
                            scl_low_ff <= 1'b1;
                            state_ff   <= i2c_host_pkg::ST_IDLE;
                        end
                    i2c_host_pkg::ST_RS_SDA:
                        if (tick) begin
                            scl_low_ff <= 1'b0;
                            state_ff   <= i2c_host_pkg::ST_RS_SCLHI;
                        end
                    i2c_host_pkg::ST_RS_SCLHI:
                        if (scl_in)
                            state_ff <= i2c_host_pkg::ST_RS_HOLD;
                    i2c_host_pkg::ST_RS_HOLD:
                        if (tick || !sda_in) begin
                            sda_low_ff <= 1'b1;
                            state_ff   <= i2c_host_pkg::ST_RS_SCL;
                        end
                    i2c_host_pkg::ST_TX_LOW:
                        if (tick) begin
                            sda_low_ff <= !shreg_ff[7];
                            scl_low_ff <= 1'b0;
                            state_ff   <= i2c_host_pkg::ST_TX_HIGH;
                        end
                    i2c_host_pkg::ST_TX_HIGH:
                        if (tick) begin
                            scl_low_ff <= 1'b1;
                            shreg_ff   <= {shreg_ff[6:0], 1'b0};
                            bit_ff     <= bit_ff + 3'h1;
                            if (bit_ff == 3'h7) begin
                                state_ff <= i2c_host_pkg::ST_ACKIN_LOW;
                            end else begin
                                state_ff <= i2c_host_pkg::ST_TX_LOW;
                            end
                        end
                    i2c_host_pkg::ST_ACKIN_LOW:
                        if (tick) begin
                            sda_low_ff <= 1'b0;
                            scl_low_ff <= 1'b0;
                            state_ff   <= i2c_host_pkg::ST_ACKIN_HIGH;
                        end
                    i2c_host_pkg::ST_ACKIN_HIGH:
                        if (tick) begin
                            ackstat_ff <= sda_in;
                            scl_low_ff <= 1'b1;
                            state_ff   <= i2c_host_pkg::ST_IDLE;
                        end
                    i2c_host_pkg::ST_ACK_LOW:
                        if (tick) begin
                            scl_low_ff <= 1'b0;
                            state_ff   <= i2c_host_pkg::ST_ACK_WAIT;
                        end
                    i2c_host_pkg::ST_ACK_WAIT:
                        if (scl_in)
                            state_ff <= i2c_host_pkg::ST_ACK_HIGH;
                    i2c_host_pkg::ST_ACK_HIGH:
                        if (tick) begin
                            scl_low_ff <= 1'b1;
                            state_ff   <= i2c_host_pkg::ST_IDLE;
                        end
                    i2c_host_pkg::ST_STOP_SDA:
                        if (!sda_in)
                            state_ff <= i2c_host_pkg::ST_STOP_SCL;
                    i2c_host_pkg::ST_STOP_SCL:
                        if (tick) begin
                            scl_low_ff <= 1'b0;
                            state_ff   <= i2c_host_pkg::ST_STOP_WAIT;
                        end
                    i2c_host_pkg::ST_STOP_WAIT:
                        if (tick) begin
                            sda_low_ff <= 1'b0;
                            state_ff   <= i2c_host_pkg::ST_STOP_DONE;
                        end
                    i2c_host_pkg::ST_STOP_DONE:
                        if (tick)
                            state_ff <= i2c_host_pkg::ST_IDLE;
                    default:
                        state_ff <= i2c_host_pkg::ST_IDLE;
                endcase
            end
        end
    end

    assign done_ev = tick && (
        state_ff == i2c_host_pkg::ST_START_SCL ||
        state_ff == i2c_host_pkg::ST_RS_SCL ||
        state_ff == i2c_host_pkg::ST_ACKIN_HIGH ||
        state_ff == i2c_host_pkg::ST_ACK_HIGH ||
        state_ff == i2c_host_pkg::ST_STOP_DONE);
    assign ev_set = done_ev || (bus_stop && enable_ff);

    // Control bits; request and ack enable bits have hardware clear
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            enable_ff         <= 1'b0;
            reload_ff         <= i2c_host_pkg::RELOAD_RESET;
            ack_value_bit     <= 1'b0;
            ack_seq_enable    <= 1'b0;
            stop_request_bit  <= 1'b0;
            start_request_bit <= 1'b0;
            rstart_ff         <= 1'b0;
        end else if (clk_en) begin
            if (reg_wr && reg_addr == i2c_host_pkg::ADDR_CTRL1)
                enable_ff <= reg_wdata[i2c_host_pkg::CTRL1_ENABLE];
            if (reg_wr && reg_addr == i2c_host_pkg::ADDR_RELOAD)
                reload_ff <= reg_wdata;
            if (reg_wr && reg_addr == i2c_host_pkg::ADDR_CTRL2
                && !busy_seq) begin
                ack_value_bit     <= reg_wdata[i2c_host_pkg::CTRL2_ACK_VALUE_BIT];
                ack_seq_enable    <= reg_wdata[i2c_host_pkg::CTRL2_ACK_SEQ_ENABLE];
                stop_request_bit  <= reg_wdata[i2c_host_pkg::CTRL2_STOP];
                rstart_ff         <= reg_wdata[i2c_host_pkg::CTRL2_RSTART];
                start_request_bit <= reg_wdata[i2c_host_pkg::CTRL2_START];
            end else if (coll || !enable_ff) begin
                ack_seq_enable    <= 1'b0;
                stop_request_bit  <= 1'b0;
                rstart_ff         <= 1'b0;
                start_request_bit <= 1'b0;
            end else begin
                if (done_ev && state_ff == i2c_host_pkg::ST_ACK_HIGH)
                    ack_seq_enable <= 1'b0;
                if (done_ev && state_ff == i2c_host_pkg::ST_STOP_DONE)
                    stop_request_bit <= 1'b0;
                if (done_ev && state_ff == i2c_host_pkg::ST_START_SCL)
                    start_request_bit <= 1'b0;
                if (done_ev && state_ff == i2c_host_pkg::ST_RS_SCL)
                    rstart_ff <= 1'b0;
            end
        end
    end

    // Buffer and sticky flags; hardware set wins over software clear
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            shift_data_buffer    <= 8'h00;
            buffer_full_flag     <= 1'b0;
            write_collision_flag <= 1'b0;
            serial_event_flag    <= 1'b0;
            bus_collision_flag   <= 1'b0;
        end else if (clk_en) begin
            if (buf_wr && (busy_seq || buffer_full_flag)) begin
                write_collision_flag <= 1'b1;
            end else if (reg_wr && reg_addr == i2c_host_pkg::ADDR_CTRL1
                         && !reg_wdata[i2c_host_pkg::CTRL1_WRITE_COLLISION_FLAG]) begin
                write_collision_flag <= 1'b0;
            end
            if (buf_wr && !busy_seq && !buffer_full_flag && enable_ff) begin
                shift_data_buffer <= reg_wdata;
                buffer_full_flag  <= 1'b1;
            end else if (coll || !enable_ff || (tick && bit_ff == 3'h7
                         && state_ff == i2c_host_pkg::ST_TX_HIGH)) begin
                buffer_full_flag <= 1'b0;
            end
            if (ev_set) begin
                serial_event_flag <= 1'b1;
            end else if (reg_wr && reg_addr == i2c_host_pkg::ADDR_FLAGS
                         && reg_wdata[i2c_host_pkg::FLAG_EVENT]) begin
                serial_event_flag <= 1'b0;
            end
            if (coll) begin
                bus_collision_flag <= 1'b1;
            end else if (reg_wr && reg_addr == i2c_host_pkg::ADDR_FLAGS
                         && reg_wdata[i2c_host_pkg::FLAG_COLL]) begin
                bus_collision_flag <= 1'b0;
            end
        end
    end

    // Bus watcher for start and stop seen
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sda_d_ff      <= 1'b1;
            scl_d_ff      <= 1'b1;
            start_seen_ff <= 1'b0;
            stop_seen_ff  <= 1'b0;
        end else if (clk_en) begin
            sda_d_ff <= sda_in;
            scl_d_ff <= scl_in;
            if (!enable_ff) begin
                start_seen_ff <= 1'b0;
                stop_seen_ff  <= 1'b0;
            end else if (bus_stop) begin
                stop_seen_ff  <= 1'b1;
                start_seen_ff <= 1'b0;
            end else if (bus_start) begin
                start_seen_ff <= 1'b1;
                stop_seen_ff  <= 1'b0;
            end
        end
    end

    // Read data one cycle after the strobe
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            reg_rdata <= 8'h00;
            if (reg_rd) begin
                unique case (reg_addr)
                    i2c_host_pkg::ADDR_CTRL1:
                        reg_rdata <= {write_collision_flag, 1'b0,
                                      enable_ff, 5'h00};
                    i2c_host_pkg::ADDR_CTRL2:
                        reg_rdata <= {1'b0, ackstat_ff, ack_value_bit,
                                      ack_seq_enable, 1'b0,
                                      stop_request_bit, rstart_ff,
                                      start_request_bit};
                    i2c_host_pkg::ADDR_STATUS:
                        reg_rdata <= {3'h0, stop_seen_ff, start_seen_ff,
                                      2'h0, buffer_full_flag};
                    i2c_host_pkg::ADDR_RELOAD: reg_rdata <= reload_ff;
                    i2c_host_pkg::ADDR_BUF: reg_rdata <= shift_data_buffer;
                    i2c_host_pkg::ADDR_FLAGS:
                        reg_rdata <= {6'h00, bus_collision_flag,
                                      serial_event_flag};
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end

endmodule : i2c_host_ctrl

// ### verif/i2c_bus_partner.sv
module i2c_bus_partner (
    // Open-drain enables, high pulls low
    input  wire logic scl_oe,
    input  wire logic sda_oe,
    input  wire logic hold_scl,
    input  wire logic hold_sda,
    // Wired lines with pull-ups
    output logic      scl,
    output logic      sda
);
    timeunit 1ns;
    timeprecision 1ps;
    assign scl = !(scl_oe || hold_scl);
    assign sda = !(sda_oe || hold_sda);
endmodule : i2c_bus_partner

// ### verif/i2c_host_ctrl_checker.sv
module i2c_host_ctrl_checker (
    // Clock and registers
    input  wire logic       mclk,
    input  wire logic       resetn,
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_rdata,
    // Bus and flags
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    input  wire logic       scl_oe,
    input  wire logic       sda_oe,
    input  wire logic       serial_event_flag,
    input  wire logic       bus_collision_flag
);
    timeunit 1ns;
    timeprecision 1ps;
    logic en_ff;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) en_ff <= 1'b0;
        else if (reg_wr && reg_addr == i2c_host_pkg::ADDR_CTRL1)
            en_ff <= reg_wdata[i2c_host_pkg::CTRL1_ENABLE];
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    a_event_held: assert property (
        serial_event_flag && !reg_wr |=> serial_event_flag)
        else $error("event flag dropped");
    a_coll_held: assert property (
        bus_collision_flag && !reg_wr |=> bus_collision_flag)
        else $error("collision flag dropped");
    a_reset_quiet: assert property ($rose(resetn) |->
        !scl_oe && !sda_oe && !serial_event_flag && !bus_collision_flag)
        else $error("not quiet after reset");
    a_off_quiet: assert property (!en_ff [*2] |-> !scl_oe && !sda_oe)
        else $error("lines driven while disabled");
    a_coll_release: assert property (
        $rose(bus_collision_flag) |-> ##[0:2] (!scl_oe && !sda_oe))
        else $error("lines held after collision");
    a_coll_cause: assert property ($rose(bus_collision_flag) |->
        !$past(sda_in) || !$past(scl_in) || !$past(sda_in, 2)
        || !$past(scl_in, 2)) else $error("collision without low line");
    a_scl_low_min: assert property (
        $fell(scl_oe) |-> $past(scl_oe, 4) || bus_collision_flag)
        else $error("clock low phase too short");
endmodule : i2c_host_ctrl_checker
bind i2c_host_ctrl i2c_host_ctrl_checker u_chk (.mclk(mclk),
    .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .scl_in(scl_in), .sda_in(sda_in), .scl_oe(scl_oe), .sda_oe(sda_oe),
    .serial_event_flag(serial_event_flag),
    .bus_collision_flag(bus_collision_flag));

// ### verif/i2c_host_ctrl_tb.sv
module i2c_host_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       mclk, resetn, reg_wr, reg_rd, hold_scl, hold_sda;
    logic       scl, sda, scl_oe, sda_oe, ev, bc;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rv;
    int         mismatches, n_tests;
    i2c_host_ctrl uut (.mclk(mclk), .resetn(resetn), .clk_en(1'b1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl),
        .scl_out(), .scl_oe(scl_oe), .sda_in(sda), .sda_out(),
        .sda_oe(sda_oe), .serial_event_flag(ev), .bus_collision_flag(bc));
    i2c_bus_partner peer (.scl_oe(scl_oe), .sda_oe(sda_oe),
        .hold_scl(hold_scl), .hold_sda(hold_sda), .scl(scl), .sda(sda));
    task automatic check(input string n, input logic [7:0] s, e);
        n_tests++;
        if (s !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask : rd
    task automatic wait_for(input bit coll);
        repeat (500) begin
            @(posedge mclk);
            #1;
            if ((coll ? bc : ev) === 1'b1) return;
        end
        check("wait", 8'h00, 8'h01);
    endtask : wait_for
    task automatic start_bus();
        wr(i2c_host_pkg::ADDR_CTRL2, 8'h01);
        wait_for(0);
        wr(i2c_host_pkg::ADDR_FLAGS, 8'h03);
    endtask : start_bus
    task automatic t_start_coll();
        @(posedge mclk) hold_sda <= 1'b1;
        wr(i2c_host_pkg::ADDR_CTRL2, 8'h01);
        wait_for(1);
        rd(i2c_host_pkg::ADDR_CTRL2);
        check("start bit", rv & 8'h01, 8'h00);
        @(posedge mclk) hold_sda <= 1'b0;
        wait_for(0);
        wr(i2c_host_pkg::ADDR_FLAGS, 8'h03);
    endtask : t_start_coll
    task automatic t_ack_stop();
        start_bus();
        wr(i2c_host_pkg::ADDR_CTRL2, 8'h02);
        wait_for(0);
        rd(i2c_host_pkg::ADDR_CTRL2);
        check("restart", {rv[1], 5'h00, scl_oe, sda_oe}, 8'h03);
        wr(i2c_host_pkg::ADDR_FLAGS, 8'h03);
        wr(i2c_host_pkg::ADDR_CTRL2, 8'h30);
        @(posedge mclk) #1;
        check("ack lines", {6'h00, scl_oe, sda_oe}, 8'h02);
        wr(i2c_host_pkg::ADDR_BUF, 8'hA5);
        rd(i2c_host_pkg::ADDR_CTRL1);
        check("write_collision_flag", rv & 8'h80, 8'h80);
        wait_for(0);
        rd(i2c_host_pkg::ADDR_CTRL2);
        check("ack end", {rv[4], 6'h00, scl_oe}, 8'h01);
        wr(i2c_host_pkg::ADDR_FLAGS, 8'h03);
        wr(i2c_host_pkg::ADDR_CTRL2, 8'h04);
        wait_for(0);
        rd(i2c_host_pkg::ADDR_STATUS);
        check("stop seen", rv & 8'h11, 8'h10);
        check("stop lines", {6'h00, scl_oe, sda_oe}, 8'h00);
        wr(i2c_host_pkg::ADDR_FLAGS, 8'h03);
        wait_for(0);
        rd(i2c_host_pkg::ADDR_CTRL2);
        check("stop bit", rv & 8'h04, 8'h00);
    endtask : t_ack_stop
    task automatic t_tx_coll();
        wr(i2c_host_pkg::ADDR_CTRL1, 8'h20);
        wr(i2c_host_pkg::ADDR_FLAGS, 8'h03);
        start_bus();
        wr(i2c_host_pkg::ADDR_BUF, 8'hFF);
        hold_sda <= 1'b1;
        wait_for(1);
        rd(i2c_host_pkg::ADDR_STATUS);
        check("tx abort", {rv[0], scl_oe, sda_oe}, 8'h00);
        @(posedge mclk) hold_sda <= 1'b0;
        wait_for(0);
        wr(i2c_host_pkg::ADDR_CTRL1, 8'h00);
        rd(i2c_host_pkg::ADDR_STATUS);
        check("seen bits off", rv & 8'h18, 8'h00);
    endtask : t_tx_coll
    task automatic tally_and_finish();
        $display("mismatches %0d of %0d checks", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        #200us;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        {resetn, reg_wr, reg_rd, hold_scl, hold_sda} = 5'h00;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        rd(i2c_host_pkg::ADDR_RELOAD);
        check("reload", rv, i2c_host_pkg::RELOAD_RESET);
        rd(3'h7);
        check("unmapped", rv, 8'h00);
        wr(i2c_host_pkg::ADDR_RELOAD, 8'h03);
        wr(i2c_host_pkg::ADDR_CTRL1, 8'h20);
        t_start_coll();
        t_ack_stop();
        t_tx_coll();
        tally_and_finish();
    end
endmodule : i2c_host_ctrl_tb
